// *** uart_slice_pkg.sv ***
package uart_slice_pkg;
  // Register byte addresses
  localparam logic [7:0] OFS_STATUS_ONE   = 8'h00;
  localparam logic [7:0] OFS_STATUS_TWO   = 8'h04;
  localparam logic [7:0] OFS_CONTROL_THR  = 8'h08;
  localparam logic [7:0] OFS_DATA         = 8'h0C;
  localparam logic [7:0] OFS_MODE         = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h18;
  // Status one field positions
  localparam int RX_FULL_POS  = 5;
  localparam int OVERRUN_POS  = 3;
  localparam int NOISE_POS    = 2;
  localparam int FRAMING_POS  = 1;
  localparam int PARITY_POS   = 0;
  // Status two field positions
  localparam int LONG_BRK_POS = 2;
  localparam int RX_ACT_POS   = 0;
  // Control three field positions
  localparam int RX9_POS      = 7;
  localparam int TX9_POS      = 6;
  localparam int SINGLE_WIRE_TX_DIRECTION_POS    = 5;
  localparam int TX_POLARITY_INVERT_POS    = 4;
  localparam int OVERRUN_IRQ_ENABLE_POS     = 3;
  localparam int NOISE_IRQ_ENABLE_POS     = 2;
  localparam int FRAMING_IRQ_ENABLE_POS     = 1;
  localparam int PARITY_IRQ_ENABLE_POS     = 0;
  // Mode register field positions
  localparam int NINE_POS     = 0;
  localparam int LOOP_POS     = 1;
  localparam int RECEIVER_SOURCE_SELECT_POS     = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Frame and break lengths in bit times
  localparam logic [3:0] FRAME_LEN_8   = 4'hA;
  localparam logic [3:0] FRAME_LEN_9   = 4'hB;
  localparam logic [3:0] BREAK_SHORT   = 4'hA;
  localparam logic [3:0] BREAK_LONG    = 4'hD;
  // Interrupt status bit positions
  localparam int EV_RX_FULL   = 0;
  localparam int EV_ERROR     = 1;
  localparam int EV_RX_START  = 2;
endpackage : uart_slice_pkg

// *** uart_slice.sv ***
// Summary of operation
// - Break is 10 bit times, 13 with long break; one more in nine-bit mode.
// - Framing errors are detected independent of long-break select.
// - Receiver-active sets on valid start bit, clears on idle line.
// - Receiver-active flag is read-only; writes leave it unchanged.
// - Nine-bit receive full clears only after ninth bit and data both read.
// - Data write sends nine bits to shifter; stored ninth bit only in nine-bit mode, else zero.
// - Single-wire mode: direction bit 0 makes transmit pin input, 1 output.
// - Polarity invert flips every transmit level: data, start, stop, break, idle.
// - Overrun flag with its enable raises an interrupt request.
// - Noise flag with its enable raises an interrupt request.
// - Framing flag with its enable raises an interrupt request.
// - Parity flag with its enable raises an interrupt request.
// - Data address: read gives receive buffer, write loads transmit buffer.
// - Eight-bit receive full clears after status-one read then data read.
// - Frame is ten bits normally, eleven bits in nine-bit mode.
module uart_slice
  import uart_slice_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Receiver core events, same clock
  input  wire logic        RX_START_VALID,
  input  wire logic        RX_IDLE_DETECT,
  input  wire logic        RX_CHAR_DONE,
  input  wire logic [8:0]  RX_CHAR_DATA,
  input  wire logic        RX_NOISE,
  input  wire logic        RX_STOP_LOW,
  input  wire logic        RX_PARITY_BAD,
  // Transmitter core interface
  output logic             TX_LOAD,
  output logic      [8:0]  TX_WORD,
  input  wire logic        TX_RAW,
  output logic             TX_OUT,
  output logic             TX_OE,
  output logic      [3:0]  BREAK_LEN,
  output logic      [3:0]  FRAME_LEN,
  // Mode selects toward the unit
  output logic             NINE_BIT_MODE,
  output logic             LOOP_MODE,
  output logic             RX_SOURCE,
  // Interrupts
  output logic             ERR_IRQ,
  output logic             IRQ
);

  // Bus timing overview
  // Address phase is taken on the edge with select, ready and transfer
  // Data phase follows in the next cycle, with no wait state
  // Writes land at the end of the data phase
  // Reads are muxed from registers during the data phase
  // Size is ignored; only whole aligned words are expected

  // Address phase capture
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  addr_q;
  logic        acc_ph;
  assign acc_ph = HSEL & HREADY & HTRANS[1];

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= RST_BYTE;
    end else begin
      wr_q   <= acc_ph & HWRITE;
      rd_q   <= acc_ph & ~HWRITE;
      addr_q <= acc_ph ? HADDR : addr_q;
    end
  end

  // Slave never stalls the bus
  // Every register is a flip-flop, so no access needs extra time
  // Error response is never used, even for unmapped offsets

  // Zero wait states; every access answers OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Strobes are decoded from the captured address
  // Decoding in the data phase keeps write data and strobe aligned
  // Unmapped offsets decode to nothing: writes drop, reads give zero

  // Decoded accesses in data phase
  logic wr_c3, wr_data, wr_mode, wr_ist, wr_imask, wr_s2;
  logic rd_s1, rd_c3, rd_data;
  assign wr_s2    = wr_q & (addr_q == OFS_STATUS_TWO);
  assign wr_c3    = wr_q & (addr_q == OFS_CONTROL_THR);
  assign wr_data  = wr_q & (addr_q == OFS_DATA);
  assign wr_mode  = wr_q & (addr_q == OFS_MODE);
  assign wr_ist   = wr_q & (addr_q == OFS_IRQ_STATUS);
  assign wr_imask = wr_q & (addr_q == OFS_IRQ_MASK);
  assign rd_s1    = rd_q & (addr_q == OFS_STATUS_ONE);
  assign rd_c3    = rd_q & (addr_q == OFS_CONTROL_THR);
  assign rd_data  = rd_q & (addr_q == OFS_DATA);

  // Control state
  logic       long_break_select_q;
  logic       tx_ninth_bit_q;
  logic       single_wire_tx_direction_q;
  logic       tx_polarity_invert_q;
  logic [3:0] err_irq_enable_q;
  logic [2:0] mode_q;

  // Control register notes
  // Long-break select stays writable in status two
  // In status two, only the receiver-active flag ignores writes
  // Ninth transmit bit holds its value between data writes
  // Software that sends mark or space parity may leave it alone
  // Error enables sit in the low nibble of control three

  // Writable control bits; receiver-active has no write path
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      long_break_select_q        <= 1'b0;
      tx_ninth_bit_q             <= 1'b0;
      single_wire_tx_direction_q <= 1'b0;
      tx_polarity_invert_q       <= 1'b0;
      err_irq_enable_q           <= 4'h0;
      mode_q                     <= 3'h0;
    end else begin
      if (wr_s2) begin
        long_break_select_q <= HWDATA[LONG_BRK_POS];
      end
      if (wr_c3) begin
        tx_ninth_bit_q             <= HWDATA[TX9_POS];
        single_wire_tx_direction_q <= HWDATA[SINGLE_WIRE_TX_DIRECTION_POS];
        tx_polarity_invert_q       <= HWDATA[TX_POLARITY_INVERT_POS];
        err_irq_enable_q           <= HWDATA[3:0];
      end
      if (wr_mode) begin
        mode_q <= HWDATA[2:0];
      end
    end
  end

  assign NINE_BIT_MODE = mode_q[NINE_POS];
  assign LOOP_MODE     = mode_q[LOOP_POS];
  assign RX_SOURCE     = mode_q[RECEIVER_SOURCE_SELECT_POS];

  // Lengths are given in bit times to the shifter
  // Nine-bit mode adds one bit to both break and frame
  // Long break adds three bit times to the short break
  // Receiver framing check never looks at break length

  // Break and frame length selection; framing check ignores break length
  always_comb begin
    BREAK_LEN = long_break_select_q ? BREAK_LONG : BREAK_SHORT;
    if (NINE_BIT_MODE) begin
      BREAK_LEN = BREAK_LEN + 4'h1;
    end
    FRAME_LEN = NINE_BIT_MODE ? FRAME_LEN_9 : FRAME_LEN_8;
  end

  // Receiver-active tracking
  // Start wins when both events fall in the same cycle
  // Useful before entering a low-power state mid-character
  // Events arrive from logic on the same clock, so no synchroniser

  // Receiver-active flag follows start and idle events
  logic receiver_active_flag_q;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      receiver_active_flag_q <= 1'b0;
    end else if (RX_START_VALID) begin
      receiver_active_flag_q <= 1'b1;
    end else if (RX_IDLE_DETECT) begin
      receiver_active_flag_q <= 1'b0;
    end
  end

  // Receive buffer and status flags
  logic [7:0] rx_buf_q;
  logic       rx_ninth_bit_q;
  logic       rx_full_flag_q;
  logic       overrun_q;
  logic       noise_flag_q;
  logic       framing_error_flag_q;
  logic       parity_error_flag_q;
  logic       armed_q;
  logic       data_seen_q;
  logic       c3_seen_q;
  logic       clear_now;
  logic       load_char;

  // Arming only counts if the flags were up when status one was read
  assign load_char = RX_CHAR_DONE & ~rx_full_flag_q;
  assign clear_now = armed_q &
                     (rd_data | data_seen_q) &
                     (~NINE_BIT_MODE | rd_c3 | c3_seen_q);

  // Clear sequence notes
  // Step one: status one read while full or overrun is set
  // Step two: data read, plus control three read in nine-bit mode
  // Data and control three reads may come in either order
  // Reads before the status one read do not count
  // A fresh character restarts the sequence from scratch
  // Hazard: a stale arm could otherwise clear a new character

  // Two-step clear sequence; a new character beats a same-cycle clear
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      armed_q     <= 1'b0;
      data_seen_q <= 1'b0;
      c3_seen_q   <= 1'b0;
    end else if (clear_now | load_char) begin
      armed_q     <= 1'b0;
      data_seen_q <= 1'b0;
      c3_seen_q   <= 1'b0;
    end else begin
      if (rd_s1 & (rx_full_flag_q | overrun_q)) begin
        armed_q <= 1'b1;
      end
      if (armed_q & rd_data) begin
        data_seen_q <= 1'b1;
      end
      if (armed_q & rd_c3) begin
        c3_seen_q <= 1'b1;
      end
    end
  end

  // Receive buffer notes
  // Error flags load together with the character
  // A character arriving while full is lost; only overrun is set
  // Error flags of the lost character are dropped as well
  // All flags clear together at the end of the clear sequence

  // Character capture; an overrun keeps the old character
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rx_buf_q             <= RST_BYTE;
      rx_ninth_bit_q       <= 1'b0;
      rx_full_flag_q       <= 1'b0;
      overrun_q            <= 1'b0;
      noise_flag_q         <= 1'b0;
      framing_error_flag_q <= 1'b0;
      parity_error_flag_q  <= 1'b0;
    end else if (load_char) begin
      rx_buf_q             <= RX_CHAR_DATA[7:0];
      rx_ninth_bit_q       <= RX_CHAR_DATA[8];
      rx_full_flag_q       <= 1'b1;
      noise_flag_q         <= RX_NOISE;
      framing_error_flag_q <= RX_STOP_LOW;
      parity_error_flag_q  <= RX_PARITY_BAD;
    end else if (RX_CHAR_DONE) begin
      overrun_q <= 1'b1;
    end else if (clear_now) begin
      rx_full_flag_q       <= 1'b0;
      overrun_q            <= 1'b0;
      noise_flag_q         <= 1'b0;
      framing_error_flag_q <= 1'b0;
      parity_error_flag_q  <= 1'b0;
    end
  end

  // Transmit buffer load hands nine bits to the shifter
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      TX_LOAD <= 1'b0;
      TX_WORD <= 9'h000;
    end else begin
      TX_LOAD <= wr_data;
      if (wr_data) begin
        TX_WORD <= {tx_ninth_bit_q & NINE_BIT_MODE, HWDATA[7:0]};
      end
    end
  end

  // Transmit pin notes
  // Inversion covers every level, idle and break included
  // Output enable high means the pin is driven
  // Pin is released only in single-wire mode with direction zero

  // Pin drive; single-wire mode may turn the pin around
  logic single_wire;
  assign single_wire = LOOP_MODE & RX_SOURCE;
  assign TX_OUT = TX_RAW ^ tx_polarity_invert_q;
  assign TX_OE  = ~single_wire | single_wire_tx_direction_q;

  // Error requests gated by their enables
  logic [3:0] err_req;
  assign err_req[3] = overrun_q & err_irq_enable_q[OVERRUN_IRQ_ENABLE_POS];
  assign err_req[2] = noise_flag_q & err_irq_enable_q[NOISE_IRQ_ENABLE_POS];
  assign err_req[1] = framing_error_flag_q & err_irq_enable_q[FRAMING_IRQ_ENABLE_POS];
  assign err_req[0] = parity_error_flag_q & err_irq_enable_q[PARITY_IRQ_ENABLE_POS];
  assign ERR_IRQ = |err_req;

  // Interrupt event notes
  // Bit zero marks a character load
  // Bit one marks a load while an enabled error is pending
  // Bit two marks a valid start bit
  // Mask has the same layout; the output is a level

  // Sticky event bits, write one to clear; a new event wins
  logic [2:0] ev_now;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  assign ev_now = {RX_START_VALID, |err_req & load_char, load_char};

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_status_q <= 3'h0;
      irq_mask_q   <= 3'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_ist ? HWDATA[2:0] : 3'h0)) | ev_now;
      if (wr_imask) begin
        irq_mask_q <= HWDATA[2:0];
      end
    end
  end

  assign IRQ = |(irq_status_q & irq_mask_q);

  // Read mux for the data phase
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (addr_q)
      OFS_STATUS_ONE:  rd_byte = {2'b00, rx_full_flag_q, 1'b0, overrun_q,
                                  noise_flag_q, framing_error_flag_q,
                                  parity_error_flag_q};
      OFS_STATUS_TWO:  rd_byte = {5'h00, long_break_select_q, 1'b0,
                                  receiver_active_flag_q};
      OFS_CONTROL_THR: rd_byte = {rx_ninth_bit_q, tx_ninth_bit_q,
                                  single_wire_tx_direction_q,
                                  tx_polarity_invert_q, err_irq_enable_q};
      OFS_DATA:        rd_byte = rx_buf_q;
      OFS_MODE:        rd_byte = {5'h00, mode_q};
      OFS_IRQ_STATUS:  rd_byte = {5'h00, irq_status_q};
      OFS_IRQ_MASK:    rd_byte = {5'h00, irq_mask_q};
      default:         rd_byte = 8'h00;
    endcase
  end

  assign HRDATA = {24'h00_0000, rd_byte};

endmodule : uart_slice

// *** uart_slice_asserts.sv ***
module uart_slice_asserts
  import uart_slice_pkg::*;
(
  // Clock, reset and bus
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic       HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  // Core side
  input wire logic       RX_CHAR_DONE,
  input wire logic       TX_LOAD,
  input wire logic       TX_RAW,
  input wire logic       TX_OUT,
  input wire logic       TX_OE,
  input wire logic [3:0] BREAK_LEN,
  input wire logic [3:0] FRAME_LEN,
  input wire logic       NINE_BIT_MODE,
  input wire logic       LOOP_MODE,
  input wire logic       RX_SOURCE,
  input wire logic       ERR_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic dwr_q;
  logic ddat_q;
  // Data-phase markers; writes may legally move polarity and enables
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      dwr_q  <= 1'b0;
      ddat_q <= 1'b0;
    end else begin
      dwr_q  <= HSEL && HREADY && HTRANS[1] && HWRITE;
      ddat_q <= HSEL && HREADY && HTRANS[1] && HWRITE && (HADDR == OFS_DATA);
    end
  end
  a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus answer not ready okay");
  a_tx_load_timing: assert property (ddat_q |=> TX_LOAD)
    else $error("no load after data write");
  a_tx_load_cause: assert property (TX_LOAD |-> $past(ddat_q))
    else $error("load without data write");
  a_tx_polarity: assert property (($changed(TX_RAW) && !$past(dwr_q)) |-> $changed(TX_OUT))
    else $error("transmit output not following raw level");
  a_err_irq_cause: assert property ($rose(ERR_IRQ) |-> $past(RX_CHAR_DONE || dwr_q))
    else $error("error request without cause");
  a_frame_len: assert property (FRAME_LEN == (NINE_BIT_MODE ? FRAME_LEN_9 : FRAME_LEN_8))
    else $error("frame length wrong");
  a_break_len: assert property ((BREAK_LEN == 4'(BREAK_SHORT + NINE_BIT_MODE))
    || (BREAK_LEN == 4'(BREAK_LONG + NINE_BIT_MODE))) else $error("break length wrong");
  a_tx_drive: assert property (!(LOOP_MODE && RX_SOURCE) |-> TX_OE)
    else $error("pin released outside single wire");
endmodule : uart_slice_asserts
bind uart_slice uart_slice_asserts u_chk (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .RX_CHAR_DONE(RX_CHAR_DONE), .TX_LOAD(TX_LOAD), .TX_RAW(TX_RAW), .TX_OUT(TX_OUT),
  .TX_OE(TX_OE), .BREAK_LEN(BREAK_LEN), .FRAME_LEN(FRAME_LEN), .NINE_BIT_MODE(NINE_BIT_MODE),
  .LOOP_MODE(LOOP_MODE), .RX_SOURCE(RX_SOURCE), .ERR_IRQ(ERR_IRQ));

// *** far_serial_model.sv ***
module far_serial_model (
  // Clock and transmit side
  input  wire logic       clk,
  input  wire logic       tx_load,
  input  wire logic [8:0] tx_word,
  output logic            tx_raw,
  // Receive events
  output logic            rx_start,
  output logic            rx_idle,
  output logic            rx_done,
  output logic [8:0]      rx_data,
  output logic            rx_noise,
  output logic            rx_stop_low,
  output logic            rx_par_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] last_word;
  initial begin
    {rx_start, rx_idle, rx_done, rx_noise, rx_stop_low, rx_par_bad} = 6'h00;
    rx_data = 9'h1FF;
    tx_raw = 1'b1;
    last_word = 9'h000;
  end
  // Shifter stand-in: one start bit low after a load, else idle high
  always @(posedge clk) begin
    tx_raw <= !tx_load;
    if (tx_load) last_word <= tx_word;
  end
  // Start of a frame, or idle line afterwards
  task automatic line_event(input logic s);
    @(posedge clk);
    rx_start <= s;
    rx_idle  <= !s;
    @(posedge clk);
    rx_start <= 1'b0;
    rx_idle  <= 1'b0;
  endtask : line_event
  // Released data shows the inverse so a stale value cannot match
  task automatic send_char(input logic [8:0] d, input logic n, f, p);
    @(posedge clk);
    {rx_done, rx_data, rx_noise, rx_stop_low, rx_par_bad} <= {1'b1, d, n, f, p};
    @(posedge clk);
    {rx_done, rx_data, rx_noise, rx_stop_low, rx_par_bad} <= {1'b0, ~d, 3'b000};
  endtask : send_char
endmodule : far_serial_model

// *** test_uart_ctrl3_status2_data_regs.sv ***
module test_uart_ctrl3_status2_data_regs
  import uart_slice_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, tx_load, tx_raw, tx_out, tx_oe;
  logic        nine, loopm, receiver_source_select, err_irq, irq, rs, ri, rdone, rn, rf, rp;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic [31:0] hwdata, hrdata, rv;
  logic [8:0]  rdat, tx_word;
  logic [3:0]  brk, frm;
  logic [3:0]  blen [4] = '{4'd10, 4'd11, 4'd13, 4'd14};
  int          miscompares, comparisons, cyc;
  uart_slice dut (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .RX_START_VALID(rs), .RX_IDLE_DETECT(ri),
    .RX_CHAR_DONE(rdone), .RX_CHAR_DATA(rdat), .RX_NOISE(rn), .RX_STOP_LOW(rf),
    .RX_PARITY_BAD(rp), .TX_LOAD(tx_load), .TX_WORD(tx_word), .TX_RAW(tx_raw), .TX_OUT(tx_out),
    .TX_OE(tx_oe), .BREAK_LEN(brk), .FRAME_LEN(frm), .NINE_BIT_MODE(nine), .LOOP_MODE(loopm),
    .RX_SOURCE(receiver_source_select), .ERR_IRQ(err_irq), .IRQ(irq));
  far_serial_model far (.clk(clk), .tx_load(tx_load), .tx_word(tx_word), .tx_raw(tx_raw),
    .rx_start(rs), .rx_idle(ri), .rx_done(rdone), .rx_data(rdat), .rx_noise(rn),
    .rx_stop_low(rf), .rx_par_bad(rp));
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One single transfer; hready is sampled at rising edges before moving on
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'b10, w};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    chk($sformatf("reg %h", a), rv, e);
  endtask : rc
  // Full clearing sequence, flags checked before and after
  task automatic clr(input logic [31:0] s1, input logic [31:0] d);
    rc(OFS_STATUS_ONE, s1);
    rc(OFS_DATA, d);
    xfer(OFS_CONTROL_THR, 1'b0, 32'h0000_0000);
    rc(OFS_STATUS_ONE, 32'h0000_0000);
  endtask : clr
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    {rst_b, hsel, haddr, htrans, hwrite, hwdata} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rc(OFS_STATUS_TWO, 32'h0000_0000);
    rc(OFS_CONTROL_THR, 32'h0000_0000);
    rc(OFS_DATA, 32'h0000_0000);
    rc(8'h1C, 32'h0000_0000);
    $display("reset test done");
    for (int j = 0; j < 4; j++) begin
      xfer(OFS_MODE, 1'b1, 32'(j % 2));
      xfer(OFS_STATUS_TWO, 1'b1, 32'((j / 2) * 4 + 1));
      @(negedge clk);
      chk("break", brk, blen[j]);
      chk("frame", frm, 10 + j % 2);
      rc(OFS_STATUS_TWO, 32'((j / 2) * 4));
    end
    far.line_event(1'b1);
    rc(OFS_STATUS_TWO, 32'h0000_0005);
    far.line_event(1'b0);
    rc(OFS_STATUS_TWO, 32'h0000_0004);
    $display("break test done");
    xfer(OFS_MODE, 1'b1, 32'h0000_0001);
    far.send_char(9'h1A5, 1'b0, 1'b0, 1'b0);
    rc(OFS_STATUS_ONE, 32'h0000_0020);
    rc(OFS_DATA, 32'h0000_00A5);
    rc(OFS_STATUS_ONE, 32'h0000_0020);
    rc(OFS_CONTROL_THR, 32'h0000_0080);
    rc(OFS_DATA, 32'h0000_00A5);
    rc(OFS_STATUS_ONE, 32'h0000_0000);
    xfer(OFS_MODE, 1'b1, 32'h0000_0000);
    far.send_char(9'h05A, 1'b0, 1'b0, 1'b0);
    rc(OFS_DATA, 32'h0000_005A);
    clr(32'h0000_0020, 32'h0000_005A);
    $display("receive test done");
    for (int i = 0; i < 4; i++) begin
      xfer(OFS_CONTROL_THR, 1'b1, 32'(1 << i));
      far.send_char(9'h0AA, i == 2, i == 1, i == 0);
      if (i == 3) far.send_char(9'h055, 1'b0, 1'b0, 1'b0);
      @(negedge clk);
      chk("err_irq", err_irq, 1);
      xfer(OFS_CONTROL_THR, 1'b1, 32'h0000_0000);
      @(negedge clk);
      chk("err_irq", err_irq, 0);
      clr(32'h20 | (1 << i), 32'h0000_00AA);
    end
    $display("error test done");
    xfer(OFS_MODE, 1'b1, 32'h0000_0001);
    xfer(OFS_CONTROL_THR, 1'b1, 32'h0000_0040);
    xfer(OFS_DATA, 1'b1, 32'h0000_003C);
    repeat (2) @(posedge clk);
    chk("tx_word", far.last_word, 9'h13C);
    xfer(OFS_DATA, 1'b1, 32'h0000_0055);
    repeat (2) @(posedge clk);
    chk("tx_word", far.last_word, 9'h155);
    rc(OFS_DATA, 32'h0000_00AA);
    xfer(OFS_CONTROL_THR, 1'b1, 32'h0000_0010);
    @(negedge clk);
    chk("tx_out", tx_out, 0);
    xfer(OFS_MODE, 1'b1, 32'h0000_0006);
    xfer(OFS_CONTROL_THR, 1'b1, 32'h0000_0000);
    @(negedge clk);
    chk("tx_oe", tx_oe, 0);
    xfer(OFS_CONTROL_THR, 1'b1, 32'h0000_0020);
    @(negedge clk);
    chk("tx_oe", tx_oe, 1);
    $display("transmit test done");
    xfer(OFS_IRQ_MASK, 1'b1, 32'h0000_0000);
    xfer(OFS_IRQ_STATUS, 1'b1, 32'h0000_0007);
    far.send_char(9'h011, 1'b0, 1'b0, 1'b0);
    rc(OFS_IRQ_STATUS, 32'h0000_0001);
    chk("irq", irq, 0);
    xfer(OFS_IRQ_MASK, 1'b1, 32'h0000_0001);
    @(negedge clk);
    chk("irq", irq, 1);
    xfer(OFS_IRQ_STATUS, 1'b1, 32'h0000_0001);
    @(negedge clk);
    chk("irq", irq, 0);
    $display("irq test done");
    summarize();
  end
endmodule : test_uart_ctrl3_status2_data_regs
